// File: trig_src_model.sv
`timescale 1ns/10ps
// ====================
// Peripheral trigger sources feeding the sequencer inputs
module trig_src_model (
    input wire clk, // Sequencer clock
    input wire [15:0] lvl, // Requested level, one bit per trigger input
    output wire [3:0] pwm_primary, // Inputs 0-3
    output wire [2:0] pwm_secondary, // Inputs 4-6
    output wire ccu4_primary, // Input 7
    output wire ccu4_secondary, // Input 8
    output wire cmp_primary1, // Input 9
    output wire [2:0] cmp_secondary, // Inputs 10-12
    output wire adc_done_primary, // Input 13
    output wire adc_done_secondary, // Input 14
    output wire external_interrupt2 // Input 15
);
    reg [15:0] lvl_r = 16'h0000;
    // Sources change just after an edge, as clocked peripherals do
    always @(posedge clk) begin
        lvl_r <= lvl;
    end
    // Trigger number to source wiring
    assign {external_interrupt2, adc_done_secondary, adc_done_primary, cmp_secondary, cmp_primary1,
        ccu4_secondary, ccu4_primary, pwm_secondary, pwm_primary} = lvl_r;
endmodule

// File: trigger_sequencer_defs.vh
`ifndef TRIGGER_SEQUENCER_DEFS_VH
`define TRIGGER_SEQUENCER_DEFS_VH

// ====================================================================
// Step command codes, field positions of the command byte
`define CMD_HI 7
`define CMD_LO 4
`define OPT_HI 3
`define OPT_LO 0
`define CMD_CONTROL 4'h0
`define CMD_ADD 4'h1
`define CMD_STROBE 3'h1
`define CMD_WAIT_RISE 4'h4
`define CMD_WAIT_FALL 4'h5
`define CMD_RESERVED 4'h6
`define CMD_IRQ 4'h7
`define CMD_TRIG 3'h4
`define CMD_JUMP 3'h5
`define CMD_LOOP0 3'h6
`define CMD_LOOP1 3'h7

// ====================================================================
// Option encodings for control and add/copy commands
`define CTRL_STROBE_LITERAL 4'h1
`define ADD_MODE 2'h0
`define COPY_MODE 2'h2
`define TGT_LIMIT_0 2'h0
`define TGT_LIMIT_1 2'h1
`define TGT_STEP_DELAY 2'h2
`define TGT_LITERAL 2'h3

// ====================================================================
// Software register select codes
`define SEL_LIMIT_0 4'h0
`define SEL_LIMIT_1 4'h1
`define SEL_STEP_DELAY 4'h2
`define SEL_LITERAL 4'h3
`define SEL_ADJUST 4'h4
`define SEL_HOLD 4'h5
`define SEL_QPTR 4'h6
`define SEL_QUEUE 4'h7

// ====================================================================
// Reset values
`define RST_WORD 16'h0000
`define RST_QPTR 5'h00

`endif

// File: trigger_sequencer_step_decoder.v
`timescale 1ns/10ps
`include "trigger_sequencer_defs.vh"

module trigger_sequencer_step_decoder (
    input wire clk, // 50 MHz sequencer clock
    input wire srst, // Synchronous reset, active high
    input wire run_en, // High runs the queue, low idles
    input wire sw_wr, // Software register write strobe
    input wire [3:0] sw_sel, // Register select for write
    input wire [3:0] sw_qidx, // Queue word index for write
    input wire [15:0] sw_wdata, // Software write data
    input wire [3:0] pwm_primary, // Primary PWM channels 1-4
    input wire [2:0] pwm_secondary, // Secondary PWM channels 1-3
    input wire ccu4_primary, // Primary capture_compare_unit4
    input wire ccu4_secondary, // Secondary capture_compare_unit4
    input wire cmp_primary1, // Primary comparator 1
    input wire [2:0] cmp_secondary, // Secondary comparators 1-3
    input wire adc_done_primary, // Primary ADC group done
    input wire adc_done_secondary, // Secondary ADC group done
    input wire external_interrupt2, // Pin-selectable external_interrupt2
    output wire busy, // Steps executing
    output wire [4:0] queue_pointer, // Active step index
    output wire [15:0] loop_counter_0, // Loop counter 0
    output wire [15:0] loop_counter_1, // Loop counter 1
    output wire [15:0] loop_limit_0, // Loop limit 0
    output wire [15:0] loop_limit_1, // Loop limit 1
    output wire [15:0] step_delay_limit, // Extra clocks per step
    output wire [15:0] literal_value, // Literal register
    output wire [15:0] adjust_value, // Adjust register
    output wire [15:0] hold_value, // Hold register
    output wire [4:0] strobe_out, // Strobe bus value
    output wire strobe_valid, // One-cycle strobe update pulse
    output wire [7:0] irq_out, // One-cycle interrupt pulses
    output wire [31:0] trigger_output_n // One-cycle trigger pulses
);

    // ================================================================
    // State codes
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_EXEC = 3'b010;
    localparam [2:0] ST_DELAY = 3'b100;

    // Sequencer state and software-visible registers
    reg [2:0] state_r;
    reg [4:0] qptr_r;
    reg [15:0] lc0_r;
    reg [15:0] lc1_r;
    reg [15:0] lim0_r;
    reg [15:0] lim1_r;
    reg [15:0] sdlim_r;
    reg [15:0] lit_r;
    reg [15:0] adj_r;
    reg [15:0] hold_r;
    // Step delay countdown and the latched step byte
    reg [15:0] dly_r;
    reg [7:0] cmd_byte_r;
    // Action outputs, all registered
    reg [4:0] strobe_r;
    reg strobe_valid_r;
    reg [7:0] irq_r;
    reg [31:0] trig_r;
    // Step queue: sixteen words, two step bytes each
    reg [15:0] queue_mem [0:15];
    // Synchroniser stages and previous sample per input
    reg [15:0] sync1_r;
    reg [15:0] sync2_r;
    reg [15:0] prev_r;
    // Decoded fields and helper nets
    wire [15:0] trig_in;
    wire [15:0] rise_w;
    wire [15:0] fall_w;
    wire [15:0] qword;
    wire [7:0] step_byte;
    wire [3:0] cmd;
    wire [3:0] opt;
    wire [4:0] tgt5;
    wire [3:0] done_cmd;
    wire [4:0] done_tgt;
    wire wait_hold;
    wire [15:0] addsrc;
    // Loop index for clearing the queue on reset
    integer i;

    // ================================================================
    // Trigger input map
    assign trig_in = {external_interrupt2, adc_done_secondary, adc_done_primary,
                      cmp_secondary, cmp_primary1, ccu4_secondary, ccu4_primary,
                      pwm_secondary, pwm_primary};

    // ================================================================
    // Per-input synchroniser and edge detect
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : g_edge
            // Two flops before use; third holds the previous sample
            always @(posedge clk) begin
                if (srst) begin
                    sync1_r[g] <= 1'b0;
                    sync2_r[g] <= 1'b0;
                    prev_r[g] <= 1'b0;
                end else begin
                    sync1_r[g] <= trig_in[g];
                    sync2_r[g] <= sync1_r[g];
                    prev_r[g] <= sync2_r[g];
                end
            end
            assign rise_w[g] = sync2_r[g] & ~prev_r[g];
            assign fall_w[g] = ~sync2_r[g] & prev_r[g];
        end
    endgenerate

    // ================================================================
    // Step fetch and field split
    assign qword = queue_mem[qptr_r[4:1]];
    assign step_byte = qptr_r[0] ? qword[15:8] : qword[7:0];
    assign cmd = step_byte[`CMD_HI:`CMD_LO];
    assign opt = step_byte[`OPT_HI:`OPT_LO];
    assign tgt5 = {cmd[0], opt};
    // Latched byte drives the pointer update at step end
    assign done_cmd = cmd_byte_r[`CMD_HI:`CMD_LO];
    assign done_tgt = {cmd_byte_r[`CMD_LO], cmd_byte_r[`OPT_HI:`OPT_LO]};

    // Wait commands stall until the selected input shows the edge
    // An edge seen before the wait starts is not remembered
    assign wait_hold = ((cmd == `CMD_WAIT_RISE) && !rise_w[opt]) ||
                       ((cmd == `CMD_WAIT_FALL) && !fall_w[opt]);

    // Copy uses hold, add uses adjust; one mux feeds all targets
    assign addsrc = opt[3] ? hold_r : adj_r;

    // ================================================================
    // Sequencer, registers and action outputs
    always @(posedge clk) begin
        if (srst) begin
            state_r <= ST_IDLE;
            qptr_r <= `RST_QPTR;
            lc0_r <= `RST_WORD;
            lc1_r <= `RST_WORD;
            lim0_r <= `RST_WORD;
            lim1_r <= `RST_WORD;
            sdlim_r <= `RST_WORD;
            lit_r <= `RST_WORD;
            adj_r <= `RST_WORD;
            hold_r <= `RST_WORD;
            dly_r <= `RST_WORD;
            cmd_byte_r <= 8'h00;
            strobe_r <= 5'h00;
            strobe_valid_r <= 1'b0;
            irq_r <= 8'h00;
            trig_r <= 32'h00000000;
            // Queue clears too, so a run after reset decodes no-ops
            for (i = 0; i < 16; i = i + 1) begin
                queue_mem[i] <= `RST_WORD;
            end
        end else begin
            // Pulse outputs last a single cycle
            strobe_valid_r <= 1'b0;
            irq_r <= 8'h00;
            trig_r <= 32'h00000000;
            case (state_r)
                ST_IDLE: begin
                    // Software writes accepted only here
                    if (sw_wr) begin
                        case (sw_sel)
                            `SEL_LIMIT_0: lim0_r <= sw_wdata;
                            `SEL_LIMIT_1: lim1_r <= sw_wdata;
                            `SEL_STEP_DELAY: sdlim_r <= sw_wdata;
                            `SEL_LITERAL: lit_r <= sw_wdata;
                            `SEL_ADJUST: adj_r <= sw_wdata;
                            `SEL_HOLD: hold_r <= sw_wdata;
                            `SEL_QPTR: qptr_r <= sw_wdata[4:0];
                            `SEL_QUEUE: queue_mem[sw_qidx] <= sw_wdata;
                            default: ;
                        endcase
                    end
                    // A write on the start edge still lands
                    if (run_en) begin
                        // Fresh run starts both loops from zero
                        lc0_r <= `RST_WORD;
                        lc1_r <= `RST_WORD;
                        state_r <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    if (!run_en) begin
                        state_r <= ST_IDLE;
                    end else if (!wait_hold) begin
                        // Step accepted; pulses show one cycle later
                        cmd_byte_r <= step_byte;
                        dly_r <= sdlim_r;
                        state_r <= ST_DELAY;
                        // Decode on the live byte, not the latched copy
                        casez (cmd)
                            `CMD_CONTROL: begin
                                // Only one control option is built; others idle
                                if (opt == `CTRL_STROBE_LITERAL) begin
                                    strobe_r <= lit_r[4:0];
                                    strobe_valid_r <= 1'b1;
                                end
                            end
                            `CMD_ADD: begin
                                if (opt[3:2] == `ADD_MODE || opt[3:2] == `COPY_MODE) begin
                                    case (opt[1:0])
                                        `TGT_LIMIT_0: lim0_r <= opt[3] ? addsrc : lim0_r + addsrc;
                                        `TGT_LIMIT_1: lim1_r <= opt[3] ? addsrc : lim1_r + addsrc;
                                        `TGT_STEP_DELAY: sdlim_r <= opt[3] ? addsrc : sdlim_r + addsrc;
                                        default: lit_r <= opt[3] ? addsrc : lit_r + addsrc;
                                    endcase
                                end
                            end
                            4'b001?: begin
                                strobe_r <= tgt5;
                                strobe_valid_r <= 1'b1;
                            end
                            `CMD_IRQ: begin
                                if (!opt[3]) begin
                                    irq_r[opt[2:0]] <= 1'b1;
                                end
                            end
                            4'b100?: trig_r[tgt5] <= 1'b1;
                            default: ;
                        endcase
                    end
                end
                ST_DELAY: begin
                    // Abort wins over the countdown
                    if (!run_en) begin
                        state_r <= ST_IDLE;
                    end else if (dly_r != 16'h0000) begin
                        dly_r <= dly_r - 16'h0001;
                    end else begin
                        state_r <= ST_EXEC;
                        // Pointer update closes the step
                        case (done_cmd[3:1])
                            `CMD_JUMP: qptr_r <= done_tgt;
                            `CMD_LOOP0: begin
                                // Equal count is kept; only the pointer moves
                                if (lc0_r == lim0_r) begin
                                    qptr_r <= qptr_r + 5'h01;
                                end else begin
                                    lc0_r <= lc0_r + 16'h0001;
                                    qptr_r <= done_tgt;
                                end
                            end
                            `CMD_LOOP1: begin
                                if (lc1_r == lim1_r) begin
                                    qptr_r <= qptr_r + 5'h01;
                                end else begin
                                    lc1_r <= lc1_r + 16'h0001;
                                    qptr_r <= done_tgt;
                                end
                            end
                            default: qptr_r <= qptr_r + 5'h01;
                        endcase
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // ================================================================
    // Output assignments
    assign busy = (state_r != ST_IDLE);
    assign queue_pointer = qptr_r;
    assign loop_counter_0 = lc0_r;
    assign loop_counter_1 = lc1_r;
    assign loop_limit_0 = lim0_r;
    assign loop_limit_1 = lim1_r;
    assign step_delay_limit = sdlim_r;
    assign literal_value = lit_r;
    assign adjust_value = adj_r;
    assign hold_value = hold_r;
    assign strobe_out = strobe_r;
    assign strobe_valid = strobe_valid_r;
    assign irq_out = irq_r;
    assign trigger_output_n = trig_r;

endmodule

// File: trigger_sequencer_step_decoder_monitor.sv
`timescale 1ns/10ps
`include "trigger_sequencer_defs.vh"
// ====================
// Port-level checks of the step decoder
module seq_step_monitor (
    input wire clk, // Sequencer clock
    input wire srst, // Sync reset
    input wire run_en, // Run request
    input wire sw_wr, // Write strobe
    input wire [3:0] sw_sel, // Write select
    input wire [15:0] sw_wdata, // Write data
    input wire busy, // Executing
    input wire [15:0] loop_counter_0, // Counter 0
    input wire [15:0] loop_counter_1, // Counter 1
    input wire [15:0] adjust_value, // Adjust register
    input wire [15:0] hold_value, // Hold register
    input wire [4:0] queue_pointer, // Step index
    input wire [4:0] strobe_out, // Strobe bus
    input wire strobe_valid, // Strobe pulse
    input wire [7:0] irq_out, // Interrupt pulses
    input wire [31:0] trigger_output_n // Trigger pulses
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    property p_trig_onehot; $onehot0(trigger_output_n); endproperty
    a_trig_onehot: assert property (p_trig_onehot) else $error("several triggers at once");
    property p_trig_gap; (|trigger_output_n) |=> !(|trigger_output_n); endproperty
    a_trig_gap: assert property (p_trig_gap) else $error("trigger pulse too long");
    property p_irq_busy; (|irq_out) |-> $past(busy) && $onehot(irq_out); endproperty
    a_irq_busy: assert property (p_irq_busy) else $error("interrupt outside a step");
    property p_strobe_pulse; strobe_valid |=> !strobe_valid; endproperty
    a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe valid too long");
    property p_strobe_hold; !strobe_valid |-> $stable(strobe_out); endproperty
    a_strobe_hold: assert property (p_strobe_hold) else $error("strobe moved unmarked");
    property p_busy_ro; busy |=> $stable(adjust_value) && $stable(hold_value); endproperty
    a_busy_ro: assert property (p_busy_ro) else $error("register written while busy");
    property p_idle_wr; !busy && sw_wr && sw_sel == `SEL_ADJUST |=> adjust_value == $past(sw_wdata); endproperty
    a_idle_wr: assert property (p_idle_wr) else $error("idle write lost");
    property p_idle_ptr; !busy && !sw_wr && !run_en |=> $stable(queue_pointer); endproperty
    a_idle_ptr: assert property (p_idle_ptr) else $error("pointer moved while idle");
    property p_start; !busy && run_en |=> busy && loop_counter_0 == 16'h0000 && loop_counter_1 == 16'h0000;
    endproperty
    a_start: assert property (p_start) else $error("run start wrong");
    property p_lc0_inc; busy && $past(busy) && $changed(loop_counter_0) |->
        loop_counter_0 == $past(loop_counter_0) + 16'h0001; endproperty
    a_lc0_inc: assert property (p_lc0_inc) else $error("counter 0 step wrong");
endmodule
bind trigger_sequencer_step_decoder seq_step_monitor u_mon (.clk(clk), .srst(srst), .run_en(run_en),
    .sw_wr(sw_wr), .sw_sel(sw_sel), .sw_wdata(sw_wdata), .busy(busy), .loop_counter_0(loop_counter_0),
    .loop_counter_1(loop_counter_1), .adjust_value(adjust_value), .hold_value(hold_value),
    .queue_pointer(queue_pointer), .strobe_out(strobe_out), .strobe_valid(strobe_valid), .irq_out(irq_out),
    .trigger_output_n(trigger_output_n));

// File: trigger_sequencer_step_decoder_tb_top.sv
`timescale 1ns/10ps
// ====================
// Self-checking bench for the step decoder
module trigger_sequencer_step_decoder_tb_top;
    typedef struct {logic [7:0] cmd; logic [31:0] t; logic [7:0] i; logic [5:0] s;} row_t;
    reg clk = 1'b0;
    reg srst = 1'b1;
    reg run_en = 1'b0;
    reg sw_wr = 1'b0;
    reg [3:0] sw_sel = 4'h0;
    reg [3:0] sw_qidx = 4'h0;
    reg [15:0] sw_wdata = 16'h0000;
    reg [15:0] lvl = 16'h8000;
    wire [3:0] pwm_primary;
    wire [2:0] pwm_secondary, cmp_secondary;
    wire ccu4_primary, ccu4_secondary, cmp_primary1, adc_done_primary, adc_done_secondary, external_interrupt2;
    wire busy, strobe_valid;
    wire [4:0] queue_pointer, strobe_out;
    wire [15:0] loop_counter_0, loop_counter_1, loop_limit_0, loop_limit_1, step_delay_limit, literal_value;
    wire [15:0] adjust_value, hold_value;
    wire [7:0] irq_out;
    wire [31:0] trigger_output_n;
    reg [31:0] acc_t;
    reg [7:0] acc_i;
    reg [5:0] acc_s;
    int n1, n2, t1a, t1b, cyc = 0, err_total = 0, comparisons = 0;
    // Command byte, then the trigger, interrupt and strobe it should give; reserved ones give nothing
    row_t rows [11] = '{'{8'h85, 32'h0000_0020, 8'h00, 6'h00}, '{8'h9F, 32'h8000_0000, 8'h00, 6'h00},
        '{8'h80, 32'h0000_0001, 8'h00, 6'h00}, '{8'h73, 32'h0, 8'h08, 6'h00}, '{8'h70, 32'h0, 8'h01, 6'h00},
        '{8'h77, 32'h0, 8'h80, 6'h00}, '{8'h7A, 32'h0, 8'h00, 6'h00}, '{8'h60, 32'h0, 8'h00, 6'h00},
        '{8'h3A, 32'h0, 8'h00, 6'h3A}, '{8'h25, 32'h0, 8'h00, 6'h25}, '{8'h01, 32'h0, 8'h00, 6'h33}};
    trig_src_model u_src (.clk(clk), .lvl(lvl), .pwm_primary(pwm_primary), .pwm_secondary(pwm_secondary),
        .ccu4_primary(ccu4_primary), .ccu4_secondary(ccu4_secondary), .cmp_primary1(cmp_primary1),
        .cmp_secondary(cmp_secondary), .adc_done_primary(adc_done_primary),
        .adc_done_secondary(adc_done_secondary), .external_interrupt2(external_interrupt2));
    trigger_sequencer_step_decoder DUT (.clk(clk), .srst(srst), .run_en(run_en), .sw_wr(sw_wr),
        .sw_sel(sw_sel), .sw_qidx(sw_qidx), .sw_wdata(sw_wdata), .pwm_primary(pwm_primary),
        .pwm_secondary(pwm_secondary), .ccu4_primary(ccu4_primary), .ccu4_secondary(ccu4_secondary),
        .cmp_primary1(cmp_primary1), .cmp_secondary(cmp_secondary), .adc_done_primary(adc_done_primary),
        .adc_done_secondary(adc_done_secondary), .external_interrupt2(external_interrupt2), .busy(busy),
        .queue_pointer(queue_pointer), .loop_counter_0(loop_counter_0), .loop_counter_1(loop_counter_1),
        .loop_limit_0(loop_limit_0), .loop_limit_1(loop_limit_1), .step_delay_limit(step_delay_limit),
        .literal_value(literal_value), .adjust_value(adjust_value), .hold_value(hold_value),
        .strobe_out(strobe_out), .strobe_valid(strobe_valid), .irq_out(irq_out),
        .trigger_output_n(trigger_output_n));
    // 50 MHz clock
    always #10 clk = ~clk;
    // Whole run is a few hundred cycles; a hang ends here
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total = err_total + 1;
            give_verdict;
        end
    end
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask
    task give_verdict;
        $display("comparisons %0d, err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Write strobe left high so back-to-back writes never drop it twice in one step
    task wr(input [3:0] s, input [3:0] q, input [15:0] d);
        sw_wr <= 1'b1;
        sw_sel <= s;
        sw_qidx <= q;
        sw_wdata <= d;
        @(posedge clk);
    endtask
    // Load three queue words, run from step 0 and gather the pulses
    task run_q(input [15:0] w0, input [15:0] w1, input [15:0] w2, input int n);
        @(posedge clk);
        wr(4'h7, 4'h0, w0);
        wr(4'h7, 4'h1, w1);
        wr(4'h7, 4'h2, w2);
        wr(4'h6, 4'h0, 16'h0000);
        sw_wr <= 1'b0;
        run_en <= 1'b1;
        acc_t = 32'h0;
        acc_i = 8'h00;
        acc_s = 6'h00;
        n1 = 0;
        n2 = 0;
        t1a = 0;
        t1b = 0;
        for (int k = 0; k < n + 3; k++) begin
            @(negedge clk);
            acc_t = acc_t | trigger_output_n;
            acc_i = acc_i | irq_out;
            if (strobe_valid === 1'b1) acc_s = {1'b1, strobe_out};
            if (trigger_output_n[2] === 1'b1) n2++;
            if (trigger_output_n[1] === 1'b1) begin
                if (n1 == 1) t1b = k;
                if (n1 == 0) t1a = k;
                n1++;
            end
            if (k == n - 1) begin
                @(posedge clk);
                run_en <= 1'b0;
            end
        end
        // Finish on a rising edge so the next stimulus starts there
        @(posedge clk);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk("pointer", 32'h0, {27'h0, queue_pointer});
        wr(4'h3, 4'h0, 16'h0013);
        foreach (rows[r]) begin
            run_q({8'h60, rows[r].cmd}, 16'h6060, 16'h6060, 3);
            chk("trigger", rows[r].t, acc_t);
            chk("irq", {24'h0, rows[r].i}, {24'h0, acc_i});
            chk("strobe", {26'h0, rows[r].s}, {26'h0, acc_s});
        end
        chk("literal", 32'h13, {16'h0, literal_value});
        // Add, copy, and a write attempted mid-run
        wr(4'h4, 4'h0, 16'h0003);
        wr(4'h0, 4'h0, 16'h0004);
        wr(4'h5, 4'h0, 16'h1234);
        fork
            run_q({8'h19, 8'h10}, 16'hA2A2, 16'h0000, 8);
            begin
                repeat (8) @(posedge clk);
                sw_wr <= 1'b1;
                sw_sel <= 4'h4;
                @(posedge clk);
                sw_wr <= 1'b0;
            end
        join
        chk("limit0", 32'h7, {16'h0, loop_limit_0});
        chk("limit1", 32'h1234, {16'h0, loop_limit_1});
        chk("adjust", 32'h3, {16'h0, adjust_value});
        chk("hold", 32'h1234, {16'h0, hold_value});
        // Two loops one after the other (steps 0-1, then steps 2-3), one extra clock per step
        wr(4'h0, 4'h0, 16'h0002);
        wr(4'h1, 4'h0, 16'h0001);
        wr(4'h2, 4'h0, 16'h0001);
        run_q({8'hC0, 8'h81}, {8'hE2, 8'h82}, {8'h00, 8'hA4}, 40);
        chk("loop0 passes", 32'd3, n1);
        chk("loop1 passes", 32'd2, n2);
        chk("loop spacing", 32'd6, t1b - t1a);
        chk("counter0", 32'h2, {16'h0, loop_counter_0});
        chk("counter1", 32'h1, {16'h0, loop_counter_1});
        chk("jump pointer", 32'h4, {27'h0, queue_pointer});
        // Wait for rise on input 13, then fall on input 15
        fork
            run_q({8'h81, 8'h4D}, {8'h82, 8'h5F}, {8'h00, 8'hA4}, 40);
            begin
                repeat (14) @(posedge clk);
                chk("early", 32'd0, n1);
                lvl <= 16'hA000;
                repeat (12) @(posedge clk);
                chk("rise", 32'd1, n1);
                chk("fall early", 32'd0, n2);
                lvl <= 16'h2000;
            end
        join
        chk("fall", 32'd1, n2);
        // Step 31 wraps to step 0, where the wait on input 13 stalls
        wr(4'h7, 4'hF, 16'h8500);
        wr(4'h6, 4'h0, 16'h001F);
        sw_wr <= 1'b0;
        run_en <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("wrap trigger", 32'h20, trigger_output_n);
        repeat (3) @(posedge clk);
        run_en <= 1'b0;
        repeat (2) @(negedge clk);
        chk("wrap pointer", 32'h0, {27'h0, queue_pointer});
        chk("stopped", 32'h0, {31'h0, busy});
        // Reset in mid-run, from step 3 into the self-jump at step 4
        @(posedge clk);
        wr(4'h6, 4'h0, 16'h0003);
        sw_wr <= 1'b0;
        run_en <= 1'b1;
        repeat (6) @(posedge clk);
        srst <= 1'b1;
        run_en <= 1'b0;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk("pointer reset", 32'h0, {27'h0, queue_pointer});
        chk("delay reset", 32'h0, {16'h0, step_delay_limit});
        chk("busy reset", 32'h0, {31'h0, busy});
        give_verdict;
    end
endmodule
